// >>> common/mpr_pkg.sv
package mpr_pkg;

  // modbus function codes served by the map
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT   = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;

  // modbus exception codes, zero means a normal answer
  localparam logic [7:0] EXC_NONE        = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FN  = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VAL = 8'h03;

  // input register word addresses, each value spans an even/odd pair
  localparam logic [15:0] IR_SERIAL      = 16'h0000;
  localparam logic [15:0] IR_CAL_DATE    = 16'h0002;
  localparam logic [15:0] IR_PRESS_HIGH  = 16'h0004;
  localparam logic [15:0] IR_PRESS_LOW   = 16'h0006;
  localparam logic [15:0] IR_PRESS_NOW   = 16'h0008;
  localparam logic [15:0] IR_PRESS_MAX   = 16'h000A;
  localparam logic [15:0] IR_PRESS_MIN   = 16'h000C;
  localparam logic [15:0] IR_TEMP_HIGH   = 16'h000E;
  localparam logic [15:0] IR_TEMP_LOW    = 16'h0010;
  localparam logic [15:0] IR_TEMP_NOW    = 16'h0012;

  // holding register word addresses
  localparam logic [15:0] HR_PRESS_UNIT  = 16'h0000;
  localparam logic [15:0] HR_TEMP_UNIT   = 16'h0001;
  localparam logic [15:0] HR_SLAVE_ADDR  = 16'h0002;
  localparam logic [15:0] HR_BAUD        = 16'h0003;
  localparam logic [15:0] HR_PARITY      = 16'h0004;

  // pressure unit codes
  localparam logic [15:0] PU_MM_H2O      = 16'h0003;
  localparam logic [15:0] PU_MM_HG       = 16'h0004;
  localparam logic [15:0] PU_PSI         = 16'h0005;
  localparam logic [15:0] PU_BAR         = 16'h0006;
  localparam logic [15:0] PU_MBAR        = 16'h0007;
  localparam logic [15:0] PU_G_CM2       = 16'h0008;
  localparam logic [15:0] PU_KG_CM2      = 16'h0009;
  localparam logic [15:0] PU_PA          = 16'h000A;
  localparam logic [15:0] PU_KPA         = 16'h000B;
  localparam logic [15:0] PU_TORR        = 16'h000C;
  localparam logic [15:0] PU_ATM         = 16'h000D;
  localparam logic [15:0] PU_M_H2O       = 16'h000E;
  localparam logic [15:0] PU_MPA         = 16'h000F;

  // temperature unit codes
  localparam logic [15:0] TU_CELSIUS     = 16'h0000;
  localparam logic [15:0] TU_KELVIN      = 16'h0001;
  localparam logic [15:0] TU_FAHRENHEIT  = 16'h0002;

  // line rate codes
  localparam logic [15:0] BD_4800        = 16'h0004;
  localparam logic [15:0] BD_9600        = 16'h0005;
  localparam logic [15:0] BD_19200       = 16'h0006;
  localparam logic [15:0] BD_38400       = 16'h0007;

  // parity codes
  localparam logic [15:0] PAR_NONE       = 16'h0000;
  localparam logic [15:0] PAR_ODD        = 16'h0001;
  localparam logic [15:0] PAR_EVEN       = 16'h0002;

  // legal slave address window
  localparam logic [15:0] SLAVE_ADDR_MIN = 16'h0001;
  localparam logic [15:0] SLAVE_ADDR_MAX = 16'h00F7;

  // factory defaults loaded by the service restore
  localparam logic [15:0] DEF_PRESS_UNIT = PU_BAR;
  localparam logic [15:0] DEF_TEMP_UNIT  = TU_CELSIUS;
  localparam logic [15:0] DEF_SLAVE_ADDR = 16'h0001;
  localparam logic [15:0] DEF_BAUD       = BD_9600;
  localparam logic [15:0] DEF_PARITY     = PAR_NONE;

  // peak tracker start values: +inf for the minimum, -inf for the maximum
  localparam logic [31:0] FLOAT_POS_INF  = 32'h7F80_0000;
  localparam logic [31:0] FLOAT_NEG_INF  = 32'hFF80_0000;
  localparam logic [31:0] FLOAT_ZERO     = 32'h0000_0000;

endpackage : mpr_pkg

// >>> design/mpr_peak_track.sv
`timescale 1ns/10ps
module mpr_peak_track #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // sample stream
  input  wire logic             clear,
  input  wire logic             sample_valid,
  input  wire logic [WIDTH-1:0] sample,
  // tracked peaks
  output logic      [WIDTH-1:0] peak_max,
  output logic      [WIDTH-1:0] peak_min
);

  if (WIDTH != 32) begin : g_width_check
    $error("mpr_peak_track serves single-precision floats only");
  end

  logic [WIDTH-1:0] max_q;
  logic [WIDTH-1:0] max_d;
  logic [WIDTH-1:0] min_q;
  logic [WIDTH-1:0] min_d;

  // maps a float to an unsigned key with the same ordering;
  // nan patterns sort beyond the infinities and are not filtered
  function automatic logic [WIDTH-1:0] order_key(
    input logic [WIDTH-1:0] f
  );
    order_key = f[WIDTH-1] ? ~f : (f | {1'b1, {(WIDTH-1){1'b0}}});
  endfunction : order_key

  always_comb begin
    max_d = max_q;
    min_d = min_q;
    if (clear) begin
      max_d = mpr_pkg::FLOAT_NEG_INF;
      min_d = mpr_pkg::FLOAT_POS_INF;
    end else if (sample_valid) begin
      if (order_key(sample) > order_key(max_q)) begin
        max_d = sample;
      end
      if (order_key(sample) < order_key(min_q)) begin
        min_d = sample;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      max_q <= mpr_pkg::FLOAT_NEG_INF;
      min_q <= mpr_pkg::FLOAT_POS_INF;
    end else begin
      max_q <= max_d;
      min_q <= min_d;
    end
  end

  assign peak_max = max_q;
  assign peak_min = min_q;

endmodule : mpr_peak_track

// >>> design/mpr_register_map.sv
// Function
// - input registers are read-only, function 4 only
// - calibration date at words 0x0002 and 0x0003
// - pressure upper limit float at 0x0004-0x0005
// - pressure lower limit float at 0x0006-0x0007
// - temperature upper limit float at 0x000E-0x000F
// - temperature lower limit float at 0x0010-0x0011
// - pressure unit codes 0x0003 to 0x000F
// - baud codes 0x0004 to 0x0007
// - parity codes none, odd, even
// - service restore reloads all factory defaults
// - restore only when pin high at power-up
// - restore independent of bus line state
// - holding registers via functions 3 and 6
`timescale 1ns/10ps
module mpr_register_map #(
  // identity value, arbitrary
  parameter logic [31:0] SERIAL_VALUE     = 32'h0000_0001,
  parameter logic [31:0] CAL_DATE_VALUE   = 32'h0000_0000,
  // span limits as single-precision floats
  parameter logic [31:0] PRESS_SPAN_HIGH  = 32'h3F80_0000,
  parameter logic [31:0] PRESS_SPAN_LOW   = 32'h0000_0000,
  parameter logic [31:0] TEMP_SPAN_HIGH   = 32'h42C8_0000,
  parameter logic [31:0] TEMP_SPAN_LOW    = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // service restore pin, sampled once at power-up
  input  wire logic        service_reset_pin,
  // configuration recalled from non-volatile storage
  input  wire logic [15:0] nv_press_unit,
  input  wire logic [15:0] nv_temp_unit,
  input  wire logic [15:0] nv_slave_addr,
  input  wire logic [15:0] nv_baud,
  input  wire logic [15:0] nv_parity,
  // measurement front end
  input  wire logic        meas_valid,
  input  wire logic [31:0] meas_pressure,
  input  wire logic [31:0] meas_temp,
  // decoded modbus single-register request
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // answer to the request
  output logic             resp_valid,
  output logic [15:0]      resp_rdata,
  output logic [7:0]       resp_exc,
  // live configuration
  output logic [15:0]      cfg_press_unit,
  output logic [15:0]      cfg_temp_unit,
  output logic [15:0]      cfg_slave_addr,
  output logic [15:0]      cfg_baud,
  output logic [15:0]      cfg_parity,
  // store request towards non-volatile storage, and restore status
  output logic             cfg_store,
  output logic             factory_restored
);

  if (PRESS_SPAN_HIGH == PRESS_SPAN_LOW) begin : g_span_check
    $error("mpr_register_map pressure span must not be empty");
  end

  // boot and configuration state
  logic        boot_done_q;
  logic        boot_done_d;
  logic        restored_q;
  logic        restored_d;
  logic        store_q;
  logic        store_d;
  logic [15:0] press_unit_q;
  logic [15:0] press_unit_d;
  logic [15:0] temp_unit_q;
  logic [15:0] temp_unit_d;
  logic [15:0] slave_addr_q;
  logic [15:0] slave_addr_d;
  logic [15:0] baud_q;
  logic [15:0] baud_d;
  logic [15:0] parity_q;
  logic [15:0] parity_d;

  // measurement state
  logic [31:0] press_now_q;
  logic [31:0] press_now_d;
  logic [31:0] temp_now_q;
  logic [31:0] temp_now_d;
  logic [31:0] press_max;
  logic [31:0] press_min;

  // answer state
  logic        resp_valid_q;
  logic        resp_valid_d;
  logic [15:0] resp_rdata_q;
  logic [15:0] resp_rdata_d;
  logic [7:0]  resp_exc_q;
  logic [7:0]  resp_exc_d;

  logic        peak_clear;

  // picks one 16-bit word out of a two-word value
  function automatic logic [15:0] word_of(
    input logic [31:0] v,
    input logic        odd
  );
    word_of = odd ? v[15:0] : v[31:16];
  endfunction : word_of

  // legality of a value written to a holding register
  function automatic logic value_ok(
    input logic [15:0] addr,
    input logic [15:0] val
  );
    case (addr)
      mpr_pkg::HR_PRESS_UNIT:
        value_ok = (val >= mpr_pkg::PU_MM_H2O) && (val <= mpr_pkg::PU_MPA);
      mpr_pkg::HR_TEMP_UNIT:
        value_ok = val <= mpr_pkg::TU_FAHRENHEIT;
      mpr_pkg::HR_SLAVE_ADDR:
        value_ok = (val >= mpr_pkg::SLAVE_ADDR_MIN) &&
                   (val <= mpr_pkg::SLAVE_ADDR_MAX);
      mpr_pkg::HR_BAUD:
        value_ok = (val >= mpr_pkg::BD_4800) && (val <= mpr_pkg::BD_38400);
      mpr_pkg::HR_PARITY:
        value_ok = val <= mpr_pkg::PAR_EVEN;
      default:
        value_ok = 1'b0;
    endcase
  endfunction : value_ok

  // the restore resets the peaks to -inf/+inf too, so stale extremes do not survive
  assign peak_clear = !boot_done_q && service_reset_pin;

  mpr_peak_track #(
    .WIDTH        (32)
  ) u_peak (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .clear        (peak_clear),
    .sample_valid (meas_valid),
    .sample       (meas_pressure),
    .peak_max     (press_max),
    .peak_min     (press_min)
  );

  // configuration, boot sampling and measurement capture
  always_comb begin
    boot_done_d  = 1'b1;
    restored_d   = restored_q;
    store_d      = 1'b0;
    press_unit_d = press_unit_q;
    temp_unit_d  = temp_unit_q;
    slave_addr_d = slave_addr_q;
    baud_d       = baud_q;
    parity_d     = parity_q;
    press_now_d  = press_now_q;
    temp_now_d   = temp_now_q;
    if (!boot_done_q) begin
      // pin sampled once, first cycle after power-up
      if (service_reset_pin) begin
        press_unit_d = mpr_pkg::DEF_PRESS_UNIT;
        temp_unit_d  = mpr_pkg::DEF_TEMP_UNIT;
        slave_addr_d = mpr_pkg::DEF_SLAVE_ADDR;
        baud_d       = mpr_pkg::DEF_BAUD;
        parity_d     = mpr_pkg::DEF_PARITY;
        restored_d   = 1'b1;
        store_d      = 1'b1;
      end else begin
        press_unit_d = nv_press_unit;
        temp_unit_d  = nv_temp_unit;
        slave_addr_d = nv_slave_addr;
        baud_d       = nv_baud;
        parity_d     = nv_parity;
      end
    end else if (req_valid && req_func == mpr_pkg::FC_WRITE_SINGLE &&
                 value_ok(req_addr, req_wdata)) begin
      store_d = 1'b1;
      case (req_addr)
        mpr_pkg::HR_PRESS_UNIT: press_unit_d = req_wdata;
        mpr_pkg::HR_TEMP_UNIT:  temp_unit_d  = req_wdata;
        mpr_pkg::HR_SLAVE_ADDR: slave_addr_d = req_wdata;
        mpr_pkg::HR_BAUD:       baud_d       = req_wdata;
        mpr_pkg::HR_PARITY:     parity_d     = req_wdata;
        default:                store_d      = 1'b0;
      endcase
    end
    if (meas_valid) begin
      press_now_d = meas_pressure;
      temp_now_d  = meas_temp;
    end
  end

  // request decode and answer
  always_comb begin
    resp_valid_d = 1'b0;
    resp_rdata_d = 16'h0000;
    resp_exc_d   = mpr_pkg::EXC_NONE;
    if (req_valid && boot_done_q) begin
      resp_valid_d = 1'b1;
      case (req_func)
        mpr_pkg::FC_READ_INPUT: begin
          case ({req_addr[15:1], 1'b0})
            mpr_pkg::IR_SERIAL:
              resp_rdata_d = word_of(SERIAL_VALUE, req_addr[0]);
            mpr_pkg::IR_CAL_DATE:
              resp_rdata_d = word_of(CAL_DATE_VALUE, req_addr[0]);
            mpr_pkg::IR_PRESS_HIGH:
              resp_rdata_d = word_of(PRESS_SPAN_HIGH, req_addr[0]);
            mpr_pkg::IR_PRESS_LOW:
              resp_rdata_d = word_of(PRESS_SPAN_LOW, req_addr[0]);
            mpr_pkg::IR_PRESS_NOW:
              resp_rdata_d = word_of(press_now_q, req_addr[0]);
            mpr_pkg::IR_PRESS_MAX:
              resp_rdata_d = word_of(press_max, req_addr[0]);
            mpr_pkg::IR_PRESS_MIN:
              resp_rdata_d = word_of(press_min, req_addr[0]);
            mpr_pkg::IR_TEMP_HIGH:
              resp_rdata_d = word_of(TEMP_SPAN_HIGH, req_addr[0]);
            mpr_pkg::IR_TEMP_LOW:
              resp_rdata_d = word_of(TEMP_SPAN_LOW, req_addr[0]);
            mpr_pkg::IR_TEMP_NOW:
              resp_rdata_d = word_of(temp_now_q, req_addr[0]);
            default:
              resp_exc_d = mpr_pkg::EXC_ILLEGAL_ADR;
          endcase
        end
        mpr_pkg::FC_READ_HOLDING: begin
          case (req_addr)
            mpr_pkg::HR_PRESS_UNIT: resp_rdata_d = press_unit_q;
            mpr_pkg::HR_TEMP_UNIT:  resp_rdata_d = temp_unit_q;
            mpr_pkg::HR_SLAVE_ADDR: resp_rdata_d = slave_addr_q;
            mpr_pkg::HR_BAUD:       resp_rdata_d = baud_q;
            mpr_pkg::HR_PARITY:     resp_rdata_d = parity_q;
            default: resp_exc_d = mpr_pkg::EXC_ILLEGAL_ADR;
          endcase
        end
        mpr_pkg::FC_WRITE_SINGLE: begin
          if (req_addr > mpr_pkg::HR_PARITY) begin
            resp_exc_d = mpr_pkg::EXC_ILLEGAL_ADR;
          end else if (!value_ok(req_addr, req_wdata)) begin
            resp_exc_d = mpr_pkg::EXC_ILLEGAL_VAL;
          end else begin
            resp_rdata_d = req_wdata;
          end
        end
        // any other function is refused as illegal
        default: resp_exc_d = mpr_pkg::EXC_ILLEGAL_FN;
      endcase
    end
  end

  // no bus input gates the restore
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_done_q  <= 1'b0;
      restored_q   <= 1'b0;
      store_q      <= 1'b0;
      press_unit_q <= mpr_pkg::DEF_PRESS_UNIT;
      temp_unit_q  <= mpr_pkg::DEF_TEMP_UNIT;
      slave_addr_q <= mpr_pkg::DEF_SLAVE_ADDR;
      baud_q       <= mpr_pkg::DEF_BAUD;
      parity_q     <= mpr_pkg::DEF_PARITY;
      press_now_q  <= mpr_pkg::FLOAT_ZERO;
      temp_now_q   <= mpr_pkg::FLOAT_ZERO;
      resp_valid_q <= 1'b0;
      resp_rdata_q <= 16'h0000;
      resp_exc_q   <= mpr_pkg::EXC_NONE;
    end else begin
      boot_done_q  <= boot_done_d;
      restored_q   <= restored_d;
      store_q      <= store_d;
      press_unit_q <= press_unit_d;
      temp_unit_q  <= temp_unit_d;
      slave_addr_q <= slave_addr_d;
      baud_q       <= baud_d;
      parity_q     <= parity_d;
      press_now_q  <= press_now_d;
      temp_now_q   <= temp_now_d;
      resp_valid_q <= resp_valid_d;
      resp_rdata_q <= resp_rdata_d;
      resp_exc_q   <= resp_exc_d;
    end
  end

  assign resp_valid       = resp_valid_q;
  assign resp_rdata       = resp_rdata_q;
  assign resp_exc         = resp_exc_q;
  assign cfg_press_unit   = press_unit_q;
  assign cfg_temp_unit    = temp_unit_q;
  assign cfg_slave_addr   = slave_addr_q;
  assign cfg_baud         = baud_q;
  assign cfg_parity       = parity_q;
  assign cfg_store        = store_q;
  assign factory_restored = restored_q;

endmodule : mpr_register_map

// >>> test/mpr_map_checker.sv
`timescale 1ns/10ps
module mpr_map_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // stimulus side
  input wire logic        service_reset_pin,
  input wire logic [15:0] nv_baud,
  input wire logic        req_valid,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  // answer and configuration
  input wire logic        resp_valid,
  input wire logic [15:0] resp_rdata,
  input wire logic [7:0]  resp_exc,
  input wire logic [15:0] cfg_slave_addr,
  input wire logic [15:0] cfg_baud,
  input wire logic [15:0] cfg_parity,
  input wire logic        cfg_store,
  input wire logic        factory_restored
);
  logic boot_d;
  logic boot_q;
  logic take;
  logic wr;
  // requests at the first edge after reset are dropped
  always_comb begin
    boot_d = 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
    end
  end
  assign take = req_valid && boot_q;
  assign wr   = take && (req_func == mpr_pkg::FC_WRITE_SINGLE);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  resp_latency_a: assert property (take |=> resp_valid)
    else $error("request not answered after one cycle");
  no_spurious_a: assert property (!take |=> !resp_valid)
    else $error("answer without request");
  exc_no_data_a: assert property (resp_valid && resp_exc != 8'h00 |->
    resp_rdata == 16'h0000) else $error("data with exception");
  bad_func_a: assert property (take && !(req_func inside {8'h03, 8'h04,
    8'h06}) |=> resp_exc == mpr_pkg::EXC_ILLEGAL_FN)
    else $error("bad function not refused");
  ir_range_a: assert property (take && req_func == 8'h04 &&
    req_addr > 16'h0013 |=> resp_exc == mpr_pkg::EXC_ILLEGAL_ADR)
    else $error("input address out of map not refused");
  hr_range_a: assert property (take && req_func inside {8'h03, 8'h06} &&
    req_addr > 16'h0004 |=> resp_exc == mpr_pkg::EXC_ILLEGAL_ADR)
    else $error("holding address out of map not refused");
  baud_write_a: assert property (wr && req_addr == 16'h0003 &&
    req_wdata inside {[16'h0004:16'h0007]} |=> resp_exc == 8'h00 &&
    cfg_store && cfg_baud == $past(req_wdata)) else $error("baud write lost");
  parity_bad_a: assert property (wr && req_addr == 16'h0004 &&
    req_wdata > 16'h0002 |=> resp_exc == mpr_pkg::EXC_ILLEGAL_VAL &&
    !cfg_store && $stable(cfg_parity)) else $error("bad parity accepted");
  cfg_hold_a: assert property (boot_q && !wr |=> !cfg_store &&
    $stable({cfg_baud, cfg_parity, cfg_slave_addr}))
    else $error("configuration changed without write");
  restore_boot_a: assert property (!boot_q && service_reset_pin |=>
    factory_restored && cfg_store && cfg_baud == mpr_pkg::DEF_BAUD &&
    cfg_slave_addr == mpr_pkg::DEF_SLAVE_ADDR) else $error("no restore");
  nv_boot_a: assert property (!boot_q && !service_reset_pin |=>
    !factory_restored && cfg_baud == $past(nv_baud))
    else $error("stored configuration not loaded");
  restored_keep_a: assert property (factory_restored |=>
    factory_restored) else $error("restore flag dropped");
  cover property (wr ##1 cfg_store);
  cover property (!boot_q && service_reset_pin);
  cover property (resp_valid && resp_exc == mpr_pkg::EXC_ILLEGAL_VAL);
endmodule : mpr_map_checker

bind mpr_register_map mpr_map_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .service_reset_pin(service_reset_pin),
  .nv_baud(nv_baud), .req_valid(req_valid), .req_func(req_func),
  .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
  .resp_rdata(resp_rdata), .resp_exc(resp_exc),
  .cfg_slave_addr(cfg_slave_addr), .cfg_baud(cfg_baud),
  .cfg_parity(cfg_parity), .cfg_store(cfg_store),
  .factory_restored(factory_restored)
);

// >>> test/mpr_master_model.sv
`timescale 1ns/10ps
module mpr_master_model (
  // clock
  input  wire logic        clk_sys,
  // request towards the map
  output logic             req_valid,
  output logic [7:0]       req_func,
  output logic [15:0]      req_addr,
  output logic [15:0]      req_wdata,
  // answer
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_rdata,
  input  wire logic [7:0]  resp_exc
);
  initial begin
    req_valid = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end
  // one word per request, any function code
  task automatic xfer(input int gap, input logic [7:0] f,
                      input logic [15:0] a, input logic [15:0] w,
                      output logic [15:0] rd, output logic [7:0] ex,
                      output logic ok);
    repeat (gap + 1) @(negedge clk_sys);
    req_valid = 1'b1;
    req_func  = f;
    req_addr  = a;
    req_wdata = w;
    @(negedge clk_sys);
    ok = resp_valid;
    rd = resp_rdata;
    ex = resp_exc;
    // idle lines carry junk so a late latch in the map shows up
    req_valid = 1'b0;
    req_func  = ~f;
    req_addr  = ~a;
    req_wdata = ~w;
  endtask : xfer
endmodule : mpr_master_model

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
  // serial value is arbitrary
  localparam logic [31:0] SER = 32'h1357_9BDF;
  localparam logic [31:0] CAL = 32'h0A0B_0C0D;
  localparam logic [31:0] PH = 32'h4120_0000, PL = 32'hBF80_0000;
  localparam logic [31:0] TH = 32'h42A0_0000, TL = 32'hC220_0000;
  localparam logic [31:0] P1 = 32'h4000_0000, P2 = 32'h3F00_0000;
  localparam logic [31:0] T1 = 32'h41A0_0000;
  typedef struct packed {
    logic [7:0] f; logic [15:0] a; logic [15:0] w;
    logic [15:0] r; logic [7:0] e;
  } mpr_row_t;
  logic        clk_sys, rst_n, service_reset_pin, meas_valid, ok;
  logic        req_valid, resp_valid, cfg_store, factory_restored;
  logic [7:0]  req_func, resp_exc, ex;
  logic [15:0] nv_press_unit, nv_temp_unit, nv_slave_addr, nv_baud;
  logic [15:0] nv_parity, req_addr, req_wdata, resp_rdata, rd;
  logic [15:0] cfg_press_unit, cfg_temp_unit, cfg_slave_addr, cfg_baud;
  logic [15:0] cfg_parity;
  logic [31:0] meas_pressure, meas_temp;
  logic [79:0] cfg_all, nv_all;
  logic [15:0] hr[5];
  logic [31:0] ir[10];
  mpr_row_t    rows[$];
  int          n_mismatch, cmp_count;
  assign cfg_all = {cfg_press_unit, cfg_temp_unit, cfg_slave_addr,
                    cfg_baud, cfg_parity};
  assign nv_all = {nv_press_unit, nv_temp_unit, nv_slave_addr,
                   nv_baud, nv_parity};
  mpr_register_map #(.SERIAL_VALUE(SER), .CAL_DATE_VALUE(CAL),
    .PRESS_SPAN_HIGH(PH), .PRESS_SPAN_LOW(PL), .TEMP_SPAN_HIGH(TH),
    .TEMP_SPAN_LOW(TL)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .service_reset_pin(service_reset_pin), .nv_press_unit(nv_press_unit),
    .nv_temp_unit(nv_temp_unit), .nv_slave_addr(nv_slave_addr),
    .nv_baud(nv_baud), .nv_parity(nv_parity), .meas_valid(meas_valid),
    .meas_pressure(meas_pressure), .meas_temp(meas_temp),
    .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
    .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .resp_exc(resp_exc),
    .cfg_press_unit(cfg_press_unit), .cfg_temp_unit(cfg_temp_unit),
    .cfg_slave_addr(cfg_slave_addr), .cfg_baud(cfg_baud),
    .cfg_parity(cfg_parity), .cfg_store(cfg_store),
    .factory_restored(factory_restored));
  mpr_master_model u_master (.clk_sys(clk_sys), .req_valid(req_valid),
    .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_exc(resp_exc));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  function automatic void add(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] w, input logic [15:0] r, input logic [7:0] e);
    rows.push_back('{f, a, w, r, e});
  endfunction : add
  // a write row, then a read back against the shadow copy
  function automatic void wr_row(input int a, input int w, input bit good);
    if (good) begin
      hr[a] = 16'(w);
    end
    add(8'h06, 16'(a), 16'(w), good ? 16'(w) : 16'h0000,
        good ? 8'h00 : 8'h03);
    add(8'h03, 16'(a), 16'h0000, hr[a], 8'h00);
  endfunction : wr_row
  task automatic power_up(input logic pin);
    @(negedge clk_sys);
    rst_n = 1'b0;
    service_reset_pin = pin;
    repeat (5) @(negedge clk_sys);
    check(cfg_all, {mpr_pkg::DEF_PRESS_UNIT, 16'h0000, 16'h0001,
      16'h0005, 16'h0000});
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(factory_restored, pin);
    check(cfg_store, pin);
    service_reset_pin = 1'b0;
  endtask : power_up
  task automatic meas(input logic [31:0] p);
    @(negedge clk_sys);
    meas_valid = 1'b1;
    meas_pressure = p;
    meas_temp = T1;
    @(negedge clk_sys);
    meas_valid = 1'b0;
    meas_pressure = ~p;
  endtask : meas
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    $display("watchdog expired");
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    service_reset_pin = 1'b0;
    meas_valid = 1'b0;
    meas_pressure = 32'h0000_0000;
    meas_temp = 32'h0000_0000;
    {nv_press_unit, nv_temp_unit, nv_slave_addr, nv_baud, nv_parity} =
      {mpr_pkg::PU_KPA, 16'h0001, 16'h0011, 16'h0007, 16'h0002};
    n_mismatch = 0;
    cmp_count = 0;
    power_up(1'b0);
    check(cfg_all, nv_all);
    $display("test stored boot done");
    hr = '{nv_press_unit, nv_temp_unit, nv_slave_addr, nv_baud, nv_parity};
    meas(P1);
    meas(P2);
    ir = '{SER, CAL, PH, PL, P2, P1, P2, TH, TL, T1};
    for (int i = 0; i < 20; i++) begin
      add(8'h04, 16'(i), 16'h0000,
          i[0] ? ir[i / 2][15:0] : ir[i / 2][31:16], 8'h00);
    end
    add(8'h04, 16'h0014, 16'h0000, 16'h0000, 8'h02);
    add(8'h03, 16'h0005, 16'h0000, 16'h0000, 8'h02);
    add(8'h06, 16'h0005, 16'h0006, 16'h0000, 8'h02);
    add(8'h10, 16'h0000, 16'h0000, 16'h0000, 8'h01);
    for (int c = 2; c <= 16; c++) wr_row(0, c, c >= 3 && c <= 15);
    for (int c = 0; c <= 3; c++) wr_row(1, c, c <= 2);
    for (int c = 3; c <= 8; c++) wr_row(3, c, c >= 4 && c <= 7);
    for (int c = 0; c <= 3; c++) wr_row(4, c, c <= 2);
    wr_row(2, 0, 1'b0);
    wr_row(2, 247, 1'b1);
    wr_row(2, 248, 1'b0);
    foreach (rows[i]) begin
      u_master.xfer(i % 3, rows[i].f, rows[i].a, rows[i].w, rd, ex, ok);
      check(ok, 1'b1);
      check(rd, rows[i].r);
      check(ex, rows[i].e);
    end
    $display("test register rows done");
    power_up(1'b1);
    check(cfg_all, {mpr_pkg::DEF_PRESS_UNIT, 16'h0000, 16'h0001,
      16'h0005, 16'h0000});
    u_master.xfer(0, 8'h04, 16'h000A, 16'h0000, rd, ex, ok);
    check(rd, 16'hFF80);
    check(factory_restored, 1'b1);
    check(cfg_store, 1'b0);
    $display("test factory restore done");
    finish_test();
  end
endmodule : testbench
